//--- dv/tb_timer_pwm_module.sv
// Purpose: self-checking bench of tmr_pwm against expected register values, with a pin model
// Assumes: ack comes one cycle after each request
// Notes: the free-running case makes the run about 66k cycles long
`timescale 1ns/10ps
`include "tmr_defines.svh"
module tb_timer_pwm_module;
  import tmr_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  tmr_wb_req_s wb_r = '0;
  logic [31:0] wb_dat_o, q, seed = 32'h0000FB65;
  logic wb_ack_o, ext_clk, irq_o, down_seen, load_r = 1'b1;
  logic [7:0] ch_i, ch_o, oe_n, own, lvl_r = 8'h00, edges_r = 8'h00;
  int error_cnt = 0, num_checks = 0, exp_cv, v;
  always #50 clk_i = ~clk_i;
  tmr_pwm u_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_i(wb_r), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .ext_clk_i(ext_clk), .ch_i(ch_i), .ch_o(ch_o), .ch_oe_n_o(oe_n), .ch_own_o(own), .irq_o(irq_o));
  tmr_pin_model u_pins (.clk_i(clk_i), .load_i(load_r), .edges_i(edges_r), .lvl_i(lvl_r),
    .ch_o_i(ch_o), .oe_n_i(oe_n), .pin_o(ch_i), .ext_clk_o(ext_clk));
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction : xs
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk
  // one classic cycle; no answer within 19 cycles counts as a mismatch
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    wb_r <= '{1'b1, 1'b1, w, a, 4'hF, d};
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    if (n >= 20) chk(32'h0, 32'h1);
    q = wb_dat_o;
    wb_r <= '0;
    @(posedge clk_i);
  endtask : wb
  task automatic close_out();
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : close_out
  initial begin
    #9500000;
    error_cnt++;
    close_out();
  end
  // ------
  // scenarios
  // ------
  initial begin
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    load_r <= 1'b0;
    @(posedge clk_i);
    chk({irq_o, own, oe_n}, {1'b0, 8'h00, 8'hFF});
    wb(1'b0, `TMR_ADR_SC, 0);
    chk(q, 0);
    wb(1'b1, `TMR_ADR_MOD, 32'h40);
    wb(1'b1, `TMR_ADR_SC, 32'h10);
    wb(1'b1, `TMR_ADR_CNT, 0);
    edges_r <= 8'h05;
    load_r <= 1'b1;
    @(posedge clk_i);
    load_r <= 1'b0;
    repeat (20) @(posedge clk_i);
    wb(1'b0, `TMR_ADR_CNT, 0);
    chk(q, 5);
    wb(1'b1, `TMR_ADR_SC, 32'h48);
    repeat (70) @(posedge clk_i);
    wb(1'b0, `TMR_ADR_SC, 0);
    chk(q, 32'hC8);
    chk(irq_o, 1'b1);
    wb(1'b1, `TMR_ADR_SC, 32'hC0);
    wb(1'b0, `TMR_ADR_SC, 0);
    chk(q, 32'hC0);
    wb(1'b1, `TMR_ADR_SC, 32'h40);
    wb(1'b0, `TMR_ADR_SC, 0);
    chk({q[7:0], irq_o}, {8'h40, 1'b0});
    wb(1'b1, `TMR_ADR_SC, 32'h48);
    repeat (70) @(posedge clk_i);
    wb(1'b0, `TMR_ADR_SC, 0);
    repeat (70) @(posedge clk_i);
    wb(1'b1, `TMR_ADR_SC, 32'h08);
    wb(1'b0, `TMR_ADR_SC, 0);
    chk({q[7:0], irq_o}, {8'h88, 1'b0});
    seed = xs(seed);
    v = int'(seed[5:0]) | 1;
    exp_cv = 0;
    wb(1'b1, 8'h40, 32'h28);
    wb(1'b1, `TMR_ADR_CNT, 0);
    wb(1'b1, 8'h44, v);
    wb(1'b0, 8'h44, 0);
    chk(q, exp_cv);
    repeat (70) @(posedge clk_i);
    exp_cv = v;
    wb(1'b0, 8'h44, 0);
    chk(q, exp_cv);
    chk({own[0], oe_n[0]}, 2'b10);
    wb(1'b1, `TMR_ADR_CNT, 0);
    wb(1'b1, 8'h44, v ^ 32'h40);
    wb(1'b1, 8'h40, 32'h28);
    repeat (70) @(posedge clk_i);
    wb(1'b0, 8'h44, 0);
    chk(q, exp_cv);
    wb(1'b1, 8'h50, 32'h1C);
    wb(1'b1, 8'h54, 32'h05);
    wb(1'b1, 8'h48, 32'h04);
    lvl_r <= 8'h02;
    repeat (70) @(posedge clk_i);
    chk({ch_o[2], oe_n[2], ch_i[2], own[1], oe_n[1]}, 5'b10111);
    wb(1'b1, `TMR_ADR_SC, 32'h28);
    down_seen = 1'b0;
    v = 0;
    repeat (30) begin
      wb(1'b0, `TMR_ADR_CNT, 0);
      if (q < v && v - q < 8) down_seen = 1'b1;
      v = q;
    end
    chk(down_seen, 1'b1);
    v = exp_cv ^ 1;
    wb(1'b1, `TMR_ADR_MOD, 0);
    wb(1'b1, `TMR_ADR_SC, 32'h08);
    wb(1'b1, `TMR_ADR_CNT, 0);
    wb(1'b1, 8'h44, v);
    repeat (100) @(posedge clk_i);
    wb(1'b0, 8'h44, 0);
    chk(q, exp_cv);
    repeat (65500) @(posedge clk_i);
    exp_cv = v;
    wb(1'b0, 8'h44, 0);
    chk(q, exp_cv);
    close_out();
  end
endmodule : tb_timer_pwm_module

//--- dv/tmr_pin_model.sv
// Purpose: far side of the timer pins, pin levels and the external count clock
// Assumes: the bench loads a burst length of external clock edges
// Notes: no pull devices, an undriven pin shows the level the bench asks for
`timescale 1ns/10ps
module tmr_pin_model (
  input wire logic clk_i,
  input wire logic load_i,
  input wire logic [7:0] edges_i,
  input wire logic [7:0] lvl_i,
  input wire logic [7:0] ch_o_i,
  input wire logic [7:0] oe_n_i,
  output logic [7:0] pin_o,
  output logic ext_clk_o
);
  logic [7:0] left_r;
  // wire level: timer value where it drives, the far side level elsewhere
  assign pin_o = (~oe_n_i & ch_o_i) | (oe_n_i & lvl_i);
  // the count clock stands low outside a burst
  always_ff @(posedge clk_i) begin
    if (load_i) begin
      left_r <= edges_i;
      ext_clk_o <= 1'b0;
    end else if (left_r != 8'h00) begin
      ext_clk_o <= ~ext_clk_o;
      if (!ext_clk_o) begin
        left_r <= left_r - 8'h01;
      end
    end else begin
      ext_clk_o <= 1'b0;
    end
  end
endmodule : tmr_pin_model

//--- rtl/tmr_defines.svh
// Purpose: register offsets, field positions and reset values of the timer
// Assumes: included by tmr_pkg and tmr_pwm by bare name
// Notes: offsets are byte addresses on a 32-bit Wishbone bus
`ifndef TMR_DEFINES_SVH
`define TMR_DEFINES_SVH
// ----------------------------------------
// geometry and map
// ----------------------------------------
`define TMR_NCH 8
`define TMR_ADR_SC 8'h00
`define TMR_ADR_CNT 8'h04
`define TMR_ADR_MOD 8'h08
`define TMR_ADR_CH_PAGE 2'h1
`define TMR_CH_STRIDE 8
// ----------------------------------------
// fields
// ----------------------------------------
`define TMR_SC_TOF 7
`define TMR_SC_OVERFLOW_IRQ_ENABLE 6
`define TMR_SC_CENTER_PWM_SELECT 5
`define TMR_CSC_CHF 7
`define TMR_CLK_OFF 2'h0
`define TMR_CLK_BUS 2'h1
// ----------------------------------------
// values
// ----------------------------------------
`define TMR_CNT_TOP 16'hFFFF
`define TMR_CNT_ZERO 16'h0000
`define TMR_RST_MOD 16'h0000
`define TMR_RST_CV 16'h0000
`endif

//--- rtl/tmr_pkg.sv
// Purpose: types shared by the timer and its bench
// Assumes: constants come from tmr_defines.svh
// Notes: all state of tmr_pwm is one packed struct
package tmr_pkg;
  `include "tmr_defines.svh"
  localparam int NCH = `TMR_NCH;

  typedef enum logic [1:0] {
    MODE_CAPT = 2'b00,
    MODE_CMP = 2'b01,
    MODE_EDGE_ALIGNED_PWM = 2'b10,
    MODE_EDGE_ALIGNED_PWM_ALT = 2'b11
  } tmr_mode_e;

  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } tmr_wb_req_s;

  typedef struct packed {
    logic [15:0] cnt;
    logic down;
    logic [6:0] pre;
    logic ext_q;
    logic overflow_flag;
    logic overflow_irq_enable;
    logic center_pwm_select;
    logic [1:0] clks;
    logic [2:0] ps;
    logic arm;
    logic [15:0] modv;
    logic [NCH-1:0][1:0] ms;
    logic [NCH-1:0][1:0] els;
    logic [NCH-1:0] chf;
    logic [NCH-1:0][15:0] cv;
    logic [NCH-1:0][15:0] cbuf;
    logic [NCH-1:0] wlo;
    logic [NCH-1:0] whi;
    logic [NCH-1:0] pin_q;
    logic [NCH-1:0] pout;
    logic [NCH-1:0] oe_n;
    logic [NCH-1:0] own;
    logic ack;
    logic [31:0] dat;
    logic irq;
  } tmr_state_s;
endpackage : tmr_pkg

//--- rtl/tmr_pwm.sv
// Purpose: 16-bit timer with eight capture, compare or PWM channels
// Assumes: classic Wishbone slave, inputs synchronous to clk_i
// Notes: one answer per request, ack one cycle after the request
//
// Chosen here: register access over Wishbone and the register addresses.
`timescale 1ns/10ps
`include "tmr_defines.svh"
module tmr_pwm (
  input wire logic clk_i,
  input wire logic rst_i,
  input tmr_pkg::tmr_wb_req_s wb_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic ext_clk_i,
  input wire logic [tmr_pkg::NCH-1:0] ch_i,
  output logic [tmr_pkg::NCH-1:0] ch_o,
  output logic [tmr_pkg::NCH-1:0] ch_oe_n_o,
  output logic [tmr_pkg::NCH-1:0] ch_own_o,
  output logic irq_o
);
  import tmr_pkg::*;

  tmr_state_s s_r;
  tmr_state_s s_nxt;
  logic req;
  logic wr;
  logic rd;
  logic src;
  logic tick;
  logic ovf;
  logic upd_pt;
  logic [15:0] lim;
  logic [6:0] pmask;
  logic [2:0] chn;
  logic ch_page;

  // ----------------------------------------
  // bus decode and counter timing
  // ----------------------------------------
  assign req = wb_i.cyc && wb_i.stb && !s_r.ack;
  assign wr = req && wb_i.we;
  assign rd = req && !wb_i.we;
  assign chn = wb_i.adr[5:3];
  assign ch_page = (wb_i.adr[7:6] == `TMR_ADR_CH_PAGE);
  // a zero modulo means free running over the full range
  assign lim = (s_r.modv == `TMR_RST_MOD) ? `TMR_CNT_TOP : s_r.modv;
  assign pmask = 7'((8'h01 << s_r.ps) - 8'h01);
  // ext pin is counted on its rising edge at bus rate
  assign src = (s_r.clks == `TMR_CLK_BUS) ||
               (s_r.clks[1] && ext_clk_i && !s_r.ext_q);
  assign tick = src && ((s_r.pre & pmask) == pmask);
  assign ovf = tick && (s_r.center_pwm_select ? (s_r.down && s_r.cnt == `TMR_CNT_ZERO)
                                  : (s_r.cnt == lim));
  assign upd_pt = tick && !s_r.down && (s_r.cnt == 16'(lim - 16'h0001));

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    logic pend;
    logic pwm;
    logic rise;
    logic fall;
    pend = 1'b0;
    pwm = 1'b0;
    rise = 1'b0;
    fall = 1'b0;
    s_nxt = s_r;
    s_nxt.ext_q = ext_clk_i;
    s_nxt.pin_q = ch_i;
    s_nxt.ack = req;
    if (src) begin
      s_nxt.pre = tick ? 7'h00 : 7'(s_r.pre + 7'h01);
    end
    if (tick) begin
      if (!s_r.center_pwm_select) begin
        s_nxt.down = 1'b0;
        s_nxt.cnt = (s_r.cnt == lim) ? `TMR_CNT_ZERO : 16'(s_r.cnt + 16'h0001);
      end else if (!s_r.down) begin
        if (s_r.cnt == lim) begin
          s_nxt.down = 1'b1;
          s_nxt.cnt = 16'(s_r.cnt - 16'h0001);
        end else begin
          s_nxt.cnt = 16'(s_r.cnt + 16'h0001);
        end
      end else begin
        if (s_r.cnt == `TMR_CNT_ZERO) begin
          s_nxt.down = 1'b0;
          s_nxt.cnt = 16'h0001;
        end else begin
          s_nxt.cnt = 16'(s_r.cnt - 16'h0001);
        end
      end
    end else if (!s_r.center_pwm_select) begin
      s_nxt.down = 1'b0;
    end

    // channels
    for (int i = 0; i < NCH; i++) begin
      pend = s_r.wlo[i] && s_r.whi[i];
      pwm = s_r.center_pwm_select || s_r.ms[i][1];
      // buffered PWM value moves to the active register only as the count leaves lim-1; other modes or a stopped clock take it at once
      if (pend && (!pwm || s_r.clks == `TMR_CLK_OFF || upd_pt)) begin
        s_nxt.cv[i] = s_r.cbuf[i];
        s_nxt.wlo[i] = 1'b0;
        s_nxt.whi[i] = 1'b0;
      end
      s_nxt.own[i] = (s_r.els[i] != 2'b00);
      s_nxt.oe_n[i] = !((s_r.els[i] != 2'b00) && (s_r.center_pwm_select || s_r.ms[i] != MODE_CAPT));
      rise = ch_i[i] && !s_r.pin_q[i];
      fall = !ch_i[i] && s_r.pin_q[i];
      if (pwm) begin
        s_nxt.pout[i] = s_r.els[i][1] ? (s_r.cnt < s_r.cv[i]) : !(s_r.cnt < s_r.cv[i]);
      end else if (tmr_mode_e'(s_r.ms[i]) == MODE_CMP) begin
        if (tick && s_r.cnt == s_r.cv[i] && s_r.els[i] != 2'b00) begin
          s_nxt.chf[i] = 1'b1;
          case (s_r.els[i])
            2'b01: s_nxt.pout[i] = !s_r.pout[i];
            2'b10: s_nxt.pout[i] = 1'b0;
            2'b11: s_nxt.pout[i] = 1'b1;
            default: s_nxt.pout[i] = s_r.pout[i];
          endcase
        end
      end else begin
        if ((s_r.els[i][0] && rise) || (s_r.els[i][1] && fall)) begin
          s_nxt.cv[i] = s_r.cnt;
          s_nxt.chf[i] = 1'b1;
        end
      end
    end

    // ----------------------------------------
    // bus reads
    // ----------------------------------------
    s_nxt.dat = 32'h0000_0000;
    if (rd) begin
      if (wb_i.adr == `TMR_ADR_SC) begin
        s_nxt.dat = {24'h000000, s_r.overflow_flag, s_r.overflow_irq_enable, s_r.center_pwm_select, s_r.clks, s_r.ps};
        // reading with the flag up arms the clear
        if (s_r.overflow_flag) begin
          s_nxt.arm = 1'b1;
        end
      end else if (wb_i.adr == `TMR_ADR_CNT) begin
        s_nxt.dat = {16'h0000, s_r.cnt};
      end else if (wb_i.adr == `TMR_ADR_MOD) begin
        s_nxt.dat = {16'h0000, s_r.modv};
      end else if (ch_page && !wb_i.adr[2]) begin
        s_nxt.dat = {24'h000000, s_r.chf[chn], 1'b0, s_r.ms[chn], s_r.els[chn], 2'b00};
      end else if (ch_page) begin
        s_nxt.dat = {16'h0000, s_r.cv[chn]};
      end
    end

    // ----------------------------------------
    // bus writes
    // ----------------------------------------
    if (wr && wb_i.sel[0]) begin
      if (wb_i.adr == `TMR_ADR_SC) begin
        s_nxt.overflow_irq_enable = wb_i.dat[`TMR_SC_OVERFLOW_IRQ_ENABLE];
        s_nxt.center_pwm_select = wb_i.dat[`TMR_SC_CENTER_PWM_SELECT];
        s_nxt.clks = wb_i.dat[4:3];
        s_nxt.ps = wb_i.dat[2:0];
        s_nxt.arm = 1'b0;
        // writing one does nothing; zero clears only after an armed read
        if (s_r.arm && !wb_i.dat[`TMR_SC_TOF]) begin
          s_nxt.overflow_flag = 1'b0;
        end
      end else if (wb_i.adr == `TMR_ADR_CNT) begin
        s_nxt.cnt = `TMR_CNT_ZERO;
        s_nxt.pre = 7'h00;
        s_nxt.down = 1'b0;
      end else if (ch_page && !wb_i.adr[2]) begin
        s_nxt.ms[chn] = wb_i.dat[5:4];
        s_nxt.els[chn] = wb_i.dat[3:2];
        if (!wb_i.dat[`TMR_CSC_CHF]) begin
          s_nxt.chf[chn] = 1'b0;
        end
        s_nxt.wlo[chn] = 1'b0;
        s_nxt.whi[chn] = 1'b0;
      end
    end
    if (wr && wb_i.adr == `TMR_ADR_MOD) begin
      if (wb_i.sel[0]) begin
        s_nxt.modv[7:0] = wb_i.dat[7:0];
      end
      if (wb_i.sel[1]) begin
        s_nxt.modv[15:8] = wb_i.dat[15:8];
      end
    end
    if (wr && ch_page && wb_i.adr[2]) begin
      if (wb_i.sel[0]) begin
        s_nxt.cbuf[chn][7:0] = wb_i.dat[7:0];
        s_nxt.wlo[chn] = 1'b1;
      end
      if (wb_i.sel[1]) begin
        s_nxt.cbuf[chn][15:8] = wb_i.dat[15:8];
        s_nxt.whi[chn] = 1'b1;
      end
    end

    // a new overflow wins over the clear and restarts the sequence
    if (ovf) begin
      s_nxt.overflow_flag = 1'b1;
      s_nxt.arm = 1'b0;
    end
    s_nxt.irq = s_nxt.overflow_flag && s_nxt.overflow_irq_enable;
  end

  // ----------------------------------------
  // state register
  // ----------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_r <= '0;
      s_r.oe_n <= '1;
      s_r.modv <= `TMR_RST_MOD;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign wb_dat_o = s_r.dat;
  assign wb_ack_o = s_r.ack;
  assign ch_o = s_r.pout;
  assign ch_oe_n_o = s_r.oe_n;
  assign ch_own_o = s_r.own;
  assign irq_o = s_r.irq;

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  pins_released_a: assert property (disable iff (1'b0) $past(rst_i) |-> ch_own_o == '0 && ch_oe_n_o == '1)
    else $error("pins claimed right after reset");
  wrap_sets_a: assert property (!s_r.center_pwm_select && tick && s_r.cnt == lim |=> s_r.cnt == 16'h0000 && s_r.overflow_flag)
    else $error("wrap did not clear counter and set flag");
  clear_seq_a: assert property (wr && wb_i.sel[0] && wb_i.adr == 8'h00 && !wb_i.dat[7] && s_r.arm && !ovf
    |=> !s_r.overflow_flag)
    else $error("armed zero write did not clear flag");
  no_arm_keep_a: assert property (wr && wb_i.sel[0] && wb_i.adr == 8'h00 && !s_r.arm && s_r.overflow_flag |=> s_r.overflow_flag)
    else $error("flag cleared without armed read");
  ovf_wins_a: assert property (ovf |=> s_r.overflow_flag && !s_r.arm)
    else $error("overflow lost during clear");
  irq_gate_a: assert property (s_r.overflow_flag && s_r.overflow_irq_enable && !(wr && wb_i.adr == 8'h00) |=> irq_o)
    else $error("interrupt request missing");
  turn_down_a: assert property (s_r.center_pwm_select && tick && !s_r.down && s_r.cnt == lim |=> s_r.down ##1 !ovf)
    else $error("center mode did not turn at modulo");
  mod_load_a: assert property (s_r.wlo[0] && s_r.whi[0] && s_r.ms[0][1] && s_r.clks != 2'h0 && !upd_pt
    && !(wr && ch_page && chn == 3'h0) |=> $stable(s_r.cv[0]))
    else $error("PWM value loaded off the period edge");
  free_load_a: assert property (s_r.wlo[0] && s_r.whi[0] && s_r.ms[0][1] && !s_r.center_pwm_select && s_r.modv == 16'h0000
    && tick && s_r.cnt == 16'hFFFE |=> s_r.cv[0] == $past(s_r.cbuf[0]))
    else $error("free-running PWM value not loaded");
  read_active_a: assert property (rd && wb_i.adr == 8'h44 |=> wb_dat_o[15:0] == $past(s_r.cv[0]) && wb_ack_o)
    else $error("value read did not return active value");
  csc_cancel_a: assert property (wr && wb_i.sel[0] && ch_page && !wb_i.adr[2] |=> !s_r.wlo[$past(chn)])
    else $error("pending value survived control write");
  ack_once_a: assert property (req |=> wb_ack_o ##1 !wb_ack_o)
    else $error("bus answer not a single cycle");

  ovf_seen_c: cover property (ovf ##1 irq_o);
  pwm_load_c: cover property (upd_pt && s_r.wlo[0] && s_r.whi[0]);
  capture_c: cover property (s_r.ms[0] == 2'b00 && !s_r.chf[0] ##1 s_r.chf[0]);
  clear_done_c: cover property (s_r.arm && s_r.overflow_flag ##1 !s_r.overflow_flag);
endmodule : tmr_pwm
